// >>> verilog/anx_defines.svh
// Purpose: Offsets, field positions, reset values and constants of the
//          auto-negotiation next page status register bank.
// Assumes: Management port with 5-bit register addresses, 16-bit data.
// Notes:   Definitions only.
//
// How it works
// - Received page bit 13 reads 1 for message page, 0 unformatted; reset 0.
// - Received page bit 12 reads partner ability to comply with message; reset 0.
// - Received page bit 11 holds toggle, opposite of previous transmitted toggle.
// - Received page bits 10:0 hold partner 11-bit code; reset all zeros.
// - Expansion bits 15:5 ignore writes and always read zero.
// - Expansion bit 4 reads 1 when parallel detection found a fault.
// - Expansion bit 3 reads 1 when partner supports next page exchange.
// - Expansion bit 2 reads a fixed 1: local device can send next pages.
// - Expansion bit 1 sets on page reception, cleared by reading the register.
// - Expansion bit 0 reads 1 when partner supports auto-negotiation.
// - Received next page word sits at address 0x05, shared with base page view.
// - Received page bit 15 reads 1 when partner wants another next page.
// - Bit 14 acknowledge comes from the negotiation machine; writes have no effect.

`ifndef ANX_DEFINES_SVH
`define ANX_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define ANX_ADDR_PARTNER_PAGE  5'h05
`define ANX_ADDR_EXPANSION     5'h06
`define ANX_ADDR_IRQ_STATUS    5'h18
`define ANX_ADDR_IRQ_MASK      5'h19
`define ANX_ADDR_PAGE_COUNT    5'h1A

// ----------------------------------------------------------------------------
// Expansion register fields
// ----------------------------------------------------------------------------
`define ANX_EXP_FAULT_BIT      4
`define ANX_EXP_PARTNER_NP_BIT 3
`define ANX_EXP_LOCAL_NP_BIT   2
`define ANX_EXP_PAGE_RX_BIT    1
`define ANX_EXP_PARTNER_AN_BIT 0
`define ANX_EXP_RSVD_HI        15
`define ANX_EXP_RSVD_LO        5
`define ANX_LOCAL_NP_VALUE     1'h1

// ----------------------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------------------
`define ANX_IRQ_PAGE_BIT       0
`define ANX_IRQ_FAULT_BIT      1
`define ANX_IRQ_NP_VIEW_BIT    2
`define ANX_IRQ_WIDTH          3

// ----------------------------------------------------------------------------
// Reset values, counter increment and counter width
// ----------------------------------------------------------------------------
`define ANX_RST_WORD           16'h0000
`define ANX_RST_IRQ            3'h0
`define ANX_RST_COUNT          8'h00
`define ANX_COUNT_ONE          8'h01
`define ANX_COUNT_WIDTH        8

`endif

// >>> verilog/anx_pkg.sv
// Purpose: Types of the auto-negotiation next page status register bank.
// Assumes: anx_defines.svh is compiled alongside.
// Notes:   Page word layout follows the management view, bit 15 first.

package anx_pkg;

   // -------------------------------------------------------------------------
   // Received link code word, next page layout
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic        more_pages_desired;
      logic        partner_ack;
      logic        message_page_flag;
      logic        partner_will_comply;
      logic        toggle;
      logic [10:0] code;
   } anx_page_t;

   // -------------------------------------------------------------------------
   // Levels reported by the negotiation machine
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic parallel_detect_fault;
      logic partner_extra_pages_supported;
      logic partner_negotiation_capable;
   } anx_link_status_t;

   // -------------------------------------------------------------------------
   // Management port request
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [4:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } anx_bus_req_t;

   // -------------------------------------------------------------------------
   // View shown at the shared address
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      ANX_VIEW_BASE = 2'b01,
      ANX_VIEW_NEXT = 2'b10
   } anx_view_t;

endpackage : anx_pkg

// >>> verilog/anx_status_regs.sv
// Purpose: Received next page word and expansion status registers of the
//          auto-negotiation function, with interrupt status and mask.
// Assumes: Page load, status levels and base page word come from the
//          negotiation machine on core_clk; bus strobes are one cycle.
// Notes:   Read data appear the cycle after the read strobe.

`include "anx_defines.svh"

module anx_status_regs
   import anx_pkg::*;
#(
   parameter int COUNT_WIDTH = `ANX_COUNT_WIDTH
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire anx_bus_req_t     bus_req,
   output      logic [15:0]      bus_rdata,
   input  wire logic             page_load,
   input  wire logic             page_is_next,
   input  wire anx_page_t        page_word,
   input  wire logic [15:0]      base_page_word,
   input  wire logic             negotiation_restart,
   input  wire anx_link_status_t link_status,
   output      logic             irq
);

   // -------------------------------------------------------------------------
   // Decoding helpers
   // -------------------------------------------------------------------------
   function automatic logic hit(input anx_bus_req_t req,
                                input logic [4:0]   addr);
      hit = req.addr == addr;
   endfunction : hit

   function automatic logic [15:0] pack_page(input anx_page_t p);
      pack_page = {p.more_pages_desired, p.partner_ack, p.message_page_flag,
                   p.partner_will_comply, p.toggle, p.code};
   endfunction : pack_page

   // -------------------------------------------------------------------------
   // Stored state
   // -------------------------------------------------------------------------
   anx_page_t                   partner_next_page_word;
   anx_view_t                   view;
   anx_link_status_t            link_level;
   logic                        page_received;
   logic [`ANX_IRQ_WIDTH-1:0]   irq_status;
   logic [`ANX_IRQ_WIDTH-1:0]   irq_mask;
   logic [COUNT_WIDTH-1:0]      page_count;
   logic                        fault_seen;

   // -------------------------------------------------------------------------
   // Next values
   // -------------------------------------------------------------------------
   anx_page_t                   next_page_word;
   anx_view_t                   next_view;
   logic                        next_page_received;
   logic [`ANX_IRQ_WIDTH-1:0]   next_irq_status;
   logic [`ANX_IRQ_WIDTH-1:0]   next_irq_mask;
   logic [COUNT_WIDTH-1:0]      next_page_count;
   logic [15:0]                 next_rdata;
   logic                        next_irq;

   // -------------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------------
   wire logic sel_page   = hit(bus_req, `ANX_ADDR_PARTNER_PAGE);
   wire logic sel_exp    = hit(bus_req, `ANX_ADDR_EXPANSION);
   wire logic sel_status = hit(bus_req, `ANX_ADDR_IRQ_STATUS);
   wire logic sel_mask   = hit(bus_req, `ANX_ADDR_IRQ_MASK);
   wire logic sel_count  = hit(bus_req, `ANX_ADDR_PAGE_COUNT);

   wire logic rd_exp     = bus_req.rd & sel_exp;
   wire logic rd_status  = bus_req.rd & sel_status;
   wire logic rd_count   = bus_req.rd & sel_count;
   wire logic wr_mask    = bus_req.wr & sel_mask;

   // -------------------------------------------------------------------------
   // Page capture
   // -------------------------------------------------------------------------
   wire logic load_next  = page_load & page_is_next;
   wire logic load_base  = page_load & ~page_is_next;

   // Only the negotiation machine writes page fields; bus writes never reach
   assign next_page_word = load_next ? page_word
                                     : partner_next_page_word;

   // Shared address shows the base page until a next page arrives
   always_comb begin
      case (view)
         ANX_VIEW_BASE: begin
            next_view = load_next ? ANX_VIEW_NEXT : ANX_VIEW_BASE;
         end
         ANX_VIEW_NEXT: begin
            next_view = (negotiation_restart | load_base) ? ANX_VIEW_BASE
                                                          : ANX_VIEW_NEXT;
         end
         default: begin
            next_view = ANX_VIEW_BASE;
         end
      endcase
   end

   // Set wins over the clearing read; flag rises with the page fields
   assign next_page_received = page_load | (page_received & ~rd_exp);

   // -------------------------------------------------------------------------
   // Page counter, cleared on read, new page wins
   // -------------------------------------------------------------------------
   always_comb begin
      if (rd_count) begin
         next_page_count = page_load ? COUNT_WIDTH'(`ANX_COUNT_ONE)
                                     : COUNT_WIDTH'(`ANX_RST_COUNT);
      end else if (page_load && page_count != {COUNT_WIDTH{1'b1}}) begin
         next_page_count = page_count + COUNT_WIDTH'(`ANX_COUNT_ONE);
      end else begin
         next_page_count = page_count;
      end
   end

   // -------------------------------------------------------------------------
   // Interrupt events
   // -------------------------------------------------------------------------
   wire logic fault_rise = link_status.parallel_detect_fault & ~fault_seen;
   wire logic [`ANX_IRQ_WIDTH-1:0] irq_event = {load_next & (view == ANX_VIEW_BASE),
                                                fault_rise,
                                                page_load};

   // Event in the clearing read cycle stays set
   assign next_irq_status = irq_event | (irq_status & {`ANX_IRQ_WIDTH{~rd_status}});
   assign next_irq_mask   = wr_mask ? bus_req.wdata[`ANX_IRQ_WIDTH-1:0] : irq_mask;
   assign next_irq        = |(next_irq_status & next_irq_mask);

   // -------------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------------
   wire logic [15:0] page_view = (view == ANX_VIEW_NEXT)
                                 ? pack_page(partner_next_page_word)
                                 : base_page_word;

   wire logic [15:0] exp_view;
   assign exp_view[`ANX_EXP_RSVD_HI:`ANX_EXP_RSVD_LO] = '0;
   assign exp_view[`ANX_EXP_FAULT_BIT]      = link_level.parallel_detect_fault;
   assign exp_view[`ANX_EXP_PARTNER_NP_BIT] =
      link_level.partner_extra_pages_supported;
   assign exp_view[`ANX_EXP_LOCAL_NP_BIT]   = `ANX_LOCAL_NP_VALUE;
   assign exp_view[`ANX_EXP_PAGE_RX_BIT]    = page_received;
   assign exp_view[`ANX_EXP_PARTNER_AN_BIT] =
      link_level.partner_negotiation_capable;

   always_comb begin
      next_rdata = `ANX_RST_WORD;
      if (bus_req.rd) begin
         if (sel_page) begin
            next_rdata = page_view;
         end else if (sel_exp) begin
            next_rdata = exp_view;
         end else if (sel_status) begin
            next_rdata[`ANX_IRQ_WIDTH-1:0] = irq_status;
         end else if (sel_mask) begin
            next_rdata[`ANX_IRQ_WIDTH-1:0] = irq_mask;
         end else if (sel_count) begin
            next_rdata[COUNT_WIDTH-1:0] = page_count;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         partner_next_page_word <= `ANX_RST_WORD;
         view                   <= ANX_VIEW_BASE;
         page_received          <= 1'b0;
      end else begin
         partner_next_page_word <= next_page_word;
         view                   <= next_view;
         page_received          <= next_page_received;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         link_level <= '0;
         fault_seen <= 1'b0;
      end else begin
         link_level <= link_status;
         fault_seen <= link_status.parallel_detect_fault;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_status <= `ANX_RST_IRQ;
         irq_mask   <= `ANX_RST_IRQ;
         page_count <= COUNT_WIDTH'(`ANX_RST_COUNT);
      end else begin
         irq_status <= next_irq_status;
         irq_mask   <= next_irq_mask;
         page_count <= next_page_count;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_rdata <= `ANX_RST_WORD;
         irq       <= 1'b0;
      end else begin
         bus_rdata <= next_rdata;
         irq       <= next_irq;
      end
   end

endmodule : anx_status_regs

// >>> test/anx_partner.sv
// Purpose: Negotiation side model that feeds received pages and link levels.
// Assumes: Tasks are called just after a rising edge of core_clk.
// Notes:   Page word is inverted once its load pulse has passed.
module anx_partner
   import anx_pkg::*;
(
   input  wire logic             core_clk,
   output      logic             page_load,
   output      logic             page_is_next,
   output      anx_page_t        page_word,
   output      logic [15:0]      base_page_word,
   output      logic             negotiation_restart,
   output      anx_link_status_t link_status
);
   timeunit 1ns;
   timeprecision 1ns;
   logic tog = 1'h0;
   initial begin
      page_load = 1'h0;
      page_is_next = 1'h0;
      page_word = '0;
      base_page_word = 16'h41E1;
      negotiation_restart = 1'h0;
      link_status = '0;
   end
   task automatic send(input logic nxt, np, mp, a2, input logic [10:0] c);
      anx_page_t w;
      tog = ~tog;
      w = '{np, 1'h1, mp, a2, tog, c};
      page_load <= 1'h1;
      page_is_next <= nxt;
      page_word <= w;
      @(posedge core_clk);
      page_load <= 1'h0;
      page_word <= ~w;
   endtask : send
   task automatic restart;
      negotiation_restart <= 1'h1;
      @(posedge core_clk);
      negotiation_restart <= 1'h0;
   endtask : restart
   task automatic set_status(input anx_link_status_t s);
      link_status <= s;
   endtask : set_status
endmodule : anx_partner

// >>> test/anx_status_regs_sva.sv
// Purpose: Port level checks of the next page status register bank.
// Assumes: One clock domain, reset active low.
// Notes:   Bound into anx_status_regs below.
`include "anx_defines.svh"
module anx_status_regs_sva
   import anx_pkg::*;
#(
   parameter int COUNT_WIDTH = 8
) (
   input wire logic             core_clk,
   input wire logic             rst_b,
   input wire anx_bus_req_t     bus_req,
   input wire logic [15:0]      bus_rdata,
   input wire logic             page_load,
   input wire logic             page_is_next,
   input wire anx_page_t        page_word,
   input wire logic [15:0]      base_page_word,
   input wire logic             negotiation_restart,
   input wire anx_link_status_t link_status,
   input wire logic             irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire rd_exp  = bus_req.rd && bus_req.addr == `ANX_ADDR_EXPANSION;
   wire rd_page = bus_req.rd && bus_req.addr == `ANX_ADDR_PARTNER_PAGE;
   property p_idle; !bus_req.rd |=> bus_rdata == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("read data not zero");
   property p_rsvd; rd_exp |=> bus_rdata[15:5] == 11'h000; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_fixed; rd_exp |=> bus_rdata[2]; endproperty
   a_fixed: assert property (p_fixed) else $error("local bit low");
   property p_set; page_load ##1 rd_exp |=> bus_rdata[1]; endproperty
   a_set: assert property (p_set) else $error("page flag not set");
   property p_cor;
      (rd_exp && !page_load) ##1 (rd_exp && !page_load) |=> !bus_rdata[1];
   endproperty
   a_cor: assert property (p_cor) else $error("flag not cleared");
   property p_keep; page_load ##1 (!rd_exp)[*3] ##1 rd_exp |=> bus_rdata[1]; endproperty
   a_keep: assert property (p_keep) else $error("flag lost");
   property p_stat;
      $stable(link_status) && rd_exp |=> {bus_rdata[4:3], bus_rdata[0]} == $past(link_status);
   endproperty
   a_stat: assert property (p_stat) else $error("status bits wrong");
   property p_word;
      page_load && page_is_next ##1 (rd_page && !page_load) |=> bus_rdata == $past(page_word, 2);
   endproperty
   a_word: assert property (p_word) else $error("page word wrong");
   c_next: cover property (page_load && page_is_next);
   c_cor: cover property (rd_exp ##1 rd_exp);
   c_irq: cover property ($rose(irq));
endmodule : anx_status_regs_sva
bind anx_status_regs anx_status_regs_sva #(.COUNT_WIDTH(COUNT_WIDTH)) u_sva (
   .core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .page_load(page_load), .page_is_next(page_is_next), .page_word(page_word),
   .base_page_word(base_page_word), .negotiation_restart(negotiation_restart),
   .link_status(link_status), .irq(irq));

// >>> test/anx_status_regs_tb.sv
// Purpose: Self-checking bench of the next page status register bank.
// Assumes: Reads are checked at the falling edge after their sampling edge.
// Notes:   Bus tasks leave the strobe up; idle drops it.
`include "anx_defines.svh"
module anx_status_regs_tb
   import anx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic             core_clk = 1'h0;
   logic             rst_b = 1'h0;
   anx_bus_req_t     bus_req = '0;
   logic [15:0]      bus_rdata, base_page_word, pend_exp;
   logic             irq, page_load, page_is_next, negotiation_restart;
   logic             pend = 1'h0;
   anx_page_t        page_word;
   anx_link_status_t link_status;
   logic [10:0]      codes [4] = '{11'h000, 11'h7FF, 11'h555, 11'h2AA};
   int               fail_count = 0, total_checks = 0, cycles = 0;
   always #25 core_clk = ~core_clk;
   anx_status_regs dut (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .page_load(page_load), .page_is_next(page_is_next),
      .page_word(page_word), .base_page_word(base_page_word),
      .negotiation_restart(negotiation_restart), .link_status(link_status), .irq(irq));
   anx_partner u_partner (.core_clk(core_clk), .page_load(page_load),
      .page_is_next(page_is_next), .page_word(page_word), .base_page_word(base_page_word),
      .negotiation_restart(negotiation_restart), .link_status(link_status));
   task automatic chk(input logic [15:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      bus_req <= '{a, d, 1'h1, 1'h0};
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      bus_req <= '{a, 16'h0000, 1'h0, 1'h1};
      @(posedge core_clk);
      pend_exp = e;
      pend = 1'h1;
   endtask : rd
   task automatic idle(input int n);
      bus_req <= '0;
      repeat (n) @(posedge core_clk);
   endtask : idle
   task automatic pg(input logic nxt, np, mp, a2, input logic [10:0] c);
      idle(0);
      u_partner.send(nxt, np, mp, a2, c);
   endtask : pg
   task automatic chk_irq(input logic e);
      idle(1);
      @(negedge core_clk);
      chk({15'h0000, irq}, {15'h0000, e});
      @(posedge core_clk);
   endtask : chk_irq
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   always @(negedge core_clk) if (pend) begin
      chk(bus_rdata, pend_exp);
      pend = 1'h0;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (2) @(posedge core_clk);
      rst_b <= 1'h1;
      @(posedge core_clk);
      rd(`ANX_ADDR_PARTNER_PAGE, base_page_word);
      rd(`ANX_ADDR_EXPANSION, 16'h0004);
      rd(`ANX_ADDR_IRQ_MASK, 16'h0000);
      rd(5'h1F, 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         pg(1'h1, i[0], i[1], i[0] ^ i[1], codes[i]);
         rd(5'h05, {i[0], 1'h1, i[1], i[0] ^ i[1], ~i[0], codes[i]});
         wr(5'h05, 16'hFFFF);
         wr(5'h06, 16'hFFFF);
         rd(5'h06, 16'h0006);
         rd(5'h06, 16'h0004);
         rd(5'h05, {i[0], 1'h1, i[1], i[0] ^ i[1], ~i[0], codes[i]});
      end
      $display("test pages done");
      for (int s = 0; s < 8; s++) begin
         u_partner.set_status(s[2:0]);
         idle(2);
         rd(5'h06, {11'h000, s[2], s[1], 1'h1, 1'h0, s[0]});
      end
      u_partner.set_status('0);
      $display("test status done");
      rd(5'h18, 16'h0007);
      wr(5'h19, 16'h0001);
      rd(5'h19, 16'h0001);
      pg(1'h1, 1'h0, 1'h1, 1'h0, 11'h001);
      chk_irq(1'h1);
      rd(5'h18, 16'h0001);
      chk_irq(1'h0);
      wr(5'h19, 16'h0000);
      pg(1'h1, 1'h0, 1'h1, 1'h0, 11'h001);
      chk_irq(1'h0);
      rd(5'h18, 16'h0001);
      rd(5'h1A, 16'h0006);
      $display("test irq done");
      idle(0);
      u_partner.restart();
      rd(5'h05, base_page_word);
      pg(1'h0, 1'h0, 1'h0, 1'h0, 11'h000);
      rd(5'h06, 16'h0006);
      rd(5'h05, base_page_word);
      $display("test view done");
      idle(2);
      give_verdict();
   end
endmodule : anx_status_regs_tb
